// file: src/cbpm_csr.sv
// Power-management control/status register bank of the CardBus function
// ************************************************************
module cbpm_csr
   import cbpm_pkg::*;
(
   input  wire logic        mclk_i,             // PCI clock, 100 MHz
   input  wire logic        rst_i,              // Global reset, async, active high
   input  wire logic        secondary_reset_in_n_i, // Secondary reset pin, active low
   input  wire logic [7:0]  cfg_addr_i,         // Config byte address
   input  wire logic        cfg_wr_i,           // Config write strobe, one cycle
   input  wire logic        cfg_rd_i,           // Config read strobe, one cycle
   input  wire logic [3:0]  cfg_be_i,           // Byte enables
   input  wire logic [31:0] cfg_wdata_i,        // Write data
   output logic      [31:0] cfg_rdata_o,        // Read data, valid cycle after cfg_rd_i
   input  wire logic        wake_event_i,       // Function wake condition, one-cycle pulse
   output logic             wake_n_o,           // Open-drain wake pin level, always low
   output logic             wake_oe_o,          // High while pulling wake pin low
   output logic             d3hot_exit_reset_o, // Internal reset pulse on D3hot to D0
   output logic             wake_context_keep_o,// Other blocks keep wake context
   output logic             sec_clk_stop_o,     // Secondary bus clock stopped (B2)
   output logic             sec_power_off_o     // Secondary bus power removed (B3)
);

   // ************************************************************
   // Pin synchroniser for the secondary reset
   // ************************************************************
   logic          srst_meta_r;
   logic          srst_sync_r;

   // First stage read only by the second
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         srst_meta_r <= 1'b1;
         srst_sync_r <= 1'b1;
      end else begin
         srst_meta_r <= secondary_reset_in_n_i;
         srst_sync_r <= srst_meta_r;
      end
   end

   wire           sec_reset = ~srst_sync_r;

   // ************************************************************
   // Register state
   // ************************************************************
   cbpm_pstate_t  pstate_r;
   cbpm_pstate_t  pstate_nxt;
   logic          wake_status_r;
   logic          wake_status_nxt;
   logic          wake_enable_r;
   logic          wake_enable_nxt;
   logic          exit_pulse_r;
   logic [31:0]   rdata_r;
   logic          oe_r;
   logic          clk_stop_r;
   logic          pwr_off_r;

   // Bridge byte is fixed; both fields are read-only
   wire   [7:0]   bridge_byte = CBPM_BRIDGE_RST;
   wire           bus_pwr_clk_ctrl_enable     = bridge_byte[CBPM_BPCC_BIT];
   wire           d3_action   = bridge_byte[CBPM_ACTION_BIT];

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Byte lane write qualifier, shared by both writable lanes
   function automatic logic lane_write(input logic       wr,
                                       input logic       sel,
                                       input logic [3:0] be,
                                       input int         lane);
      return wr & sel & be[lane];
   endfunction

   // Power state as it stands after this edge; a held secondary
   // reset wins, so the bus actions never run ahead of the state
   function automatic cbpm_pstate_t pstate_after(input logic         wr,
                                                  input logic [1:0]   code,
                                                  input cbpm_pstate_t cur,
                                                  input logic         hold_d0);
      cbpm_pstate_t nxt;
      nxt = wr ? cbpm_pstate_t'(code) : cur;
      if (hold_d0) begin
         nxt = CBPM_D0;
      end
      return nxt;
   endfunction

   // True for a write that takes the function from D3hot to D0
   function automatic logic leaves_d3hot(input cbpm_pstate_t cur,
                                         input logic         wr,
                                         input logic [1:0]   code);
      return (cur == CBPM_D3HOT) & wr & (cbpm_pstate_t'(code) == CBPM_D0);
   endfunction

   // ************************************************************
   // Access decode
   // ************************************************************
   wire           hit     = (cfg_addr_i & CBPM_DWORD_MASK) == CBPM_PMCSR_OFS;
   wire           wr_lo   = lane_write(cfg_wr_i, hit, cfg_be_i, CBPM_LO_LANE);
   wire           wr_hi   = lane_write(cfg_wr_i, hit, cfg_be_i, CBPM_HI_LANE);
   wire           clr_st  = wr_hi & cfg_wdata_i[CBPM_STATUS_BIT];
   wire   [1:0]   new_ps  = cfg_wdata_i[CBPM_PSTATE_LSB +: 2];

   // Status and enable words as software sees them
   logic  [15:0]  pmcsr_word;
   always_comb begin
      pmcsr_word                                = CBPM_PMCSR_RST;
      pmcsr_word[CBPM_STATUS_BIT]               = wake_status_r;
      pmcsr_word[CBPM_ENABLE_BIT]               = wake_enable_r;
      pmcsr_word[CBPM_PSTATE_LSB +: 2]          = pstate_r;
   end

   wire   [31:0]  rd_word = hit ? {8'h00, bridge_byte, pmcsr_word} : 32'h0000_0000;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Event beats a same-cycle clear so no wake is lost
   assign wake_status_nxt = wake_event_i | (wake_status_r & ~clr_st);
   assign wake_enable_nxt = wr_hi ? cfg_wdata_i[CBPM_ENABLE_BIT] : wake_enable_r;
   assign pstate_nxt      = pstate_after(wr_lo, new_ps, pstate_r, sec_reset);

   // Leaving D3hot for D0 triggers the internal reset elsewhere
   wire           d3_exit = leaves_d3hot(pstate_r, wr_lo, new_ps);

   // ************************************************************
   // Registers under global reset; power state also under secondary reset
   // ************************************************************
   // The D3hot exit pulse never touches these flops
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wake_enable_r <= CBPM_PMCSR_RST[CBPM_ENABLE_BIT];
         wake_status_r <= CBPM_PMCSR_RST[CBPM_STATUS_BIT];
      end else begin
         wake_enable_r <= wake_enable_nxt;
         wake_status_r <= wake_status_nxt;
      end
   end

   // Power state also cleared by secondary reset, kept on D3hot exit
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pstate_r <= CBPM_D0;
      end else if (sec_reset) begin
         pstate_r <= CBPM_D0;
      end else begin
         pstate_r <= pstate_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Wake pulled low only while status and enable are both set
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= wake_status_nxt & wake_enable_nxt;
      end
   end

   // Secondary bus actions only through the enabled control mechanism
   wire           in_d3 = (pstate_nxt == CBPM_D3HOT) & bus_pwr_clk_ctrl_enable;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_stop_r <= 1'b0;
         pwr_off_r  <= 1'b0;
      end else begin
         clk_stop_r <= in_d3 & d3_action;
         pwr_off_r  <= in_d3 & ~d3_action;
      end
   end

   // Reset pulse and read data
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         exit_pulse_r <= 1'b0;
         rdata_r      <= 32'h0000_0000;
      end else begin
         exit_pulse_r <= d3_exit & ~sec_reset;
         rdata_r      <= cfg_rd_i ? rd_word : rdata_r;
      end
   end

   assign cfg_rdata_o         = rdata_r;
   assign wake_n_o            = 1'b0;
   assign wake_oe_o           = oe_r;
   assign d3hot_exit_reset_o  = exit_pulse_r;
   assign wake_context_keep_o = wake_enable_r;
   assign sec_clk_stop_o      = clk_stop_r;
   assign sec_power_off_o     = pwr_off_r;

endmodule // cbpm_csr

// file: src/cbpm_pkg.sv
// Constants for the CardBus power-management control and status registers
package cbpm_pkg;

   // ************************************************************
   // Configuration space layout
   // ************************************************************
   localparam logic [7:0]  CBPM_PMCSR_OFS     = 8'ha4;  // Control/status word, bytes a4-a5
   localparam logic [7:0]  CBPM_BRIDGE_OFS    = 8'ha6;  // Bridge extension byte
   localparam logic [7:0]  CBPM_DWORD_MASK    = 8'hfc;  // Dword-aligned decode
   localparam int          CBPM_BRIDGE_LANE   = 2;      // Byte lane of offset a6

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int          CBPM_STATUS_BIT    = 15;     // wake_status, write 1 to clear
   localparam int          CBPM_ENABLE_BIT    = 8;      // wake_enable
   localparam int          CBPM_PSTATE_LSB    = 0;      // power_state_field, 2 bits
   localparam int          CBPM_BPCC_BIT      = 7;      // bus_pwr_clk_ctrl_enable
   localparam int          CBPM_ACTION_BIT    = 6;      // d3hot_secondary_action
   localparam int          CBPM_LO_LANE       = 0;      // Byte lane holding power state
   localparam int          CBPM_HI_LANE       = 1;      // Byte lane holding enable/status

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] CBPM_PMCSR_RST     = 16'h0000;
   localparam logic [7:0]  CBPM_BRIDGE_RST    = 8'hc0;  // Control enabled, clock stop in D3hot

   // ************************************************************
   // Power states
   // ************************************************************
   typedef enum logic [1:0] {
      CBPM_D0    = 2'h0,
      CBPM_D1    = 2'h1,
      CBPM_D2    = 2'h2,
      CBPM_D3HOT = 2'h3
   } cbpm_pstate_t;

endpackage : cbpm_pkg

// file: test/cbpm_csr_sva.sv
// Assertion checker for the power-management register bank
module cbpm_csr_sva (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        secondary_reset_in_n_i,
   input wire logic [7:0]  cfg_addr_i,
   input wire logic        cfg_wr_i,
   input wire logic        cfg_rd_i,
   input wire logic [3:0]  cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic        wake_event_i,
   input wire logic        wake_n_o,
   input wire logic        wake_oe_o,
   input wire logic        d3hot_exit_reset_o,
   input wire logic        wake_context_keep_o,
   input wire logic        sec_clk_stop_o,
   input wire logic        sec_power_off_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // Dword a4 decode, low address bits ignored
   wire hit_w = cfg_addr_i[7:2] == 6'h29;
   sequence clr_wr_s;
      cfg_wr_i && hit_w && cfg_be_i[1] && cfg_wdata_i[15];
   endsequence
   chk_oe_gated: assert property (wake_oe_o |-> wake_context_keep_o) else $error("wake without enable");
   chk_event_raises_oe: assert property (
      wake_event_i && wake_context_keep_o && !(cfg_wr_i && hit_w && cfg_be_i[1]) |=> wake_oe_o)
      else $error("wake event not driven");
   chk_clear_drops: assert property (clr_wr_s ##0 !wake_event_i |=> !wake_oe_o) else $error("clear kept wake");
   chk_pulse_single: assert property (d3hot_exit_reset_o |=> !d3hot_exit_reset_o) else $error("long pulse");
   chk_pulse_cause: assert property (
      $rose(d3hot_exit_reset_o) |-> $past(sec_clk_stop_o) && !sec_clk_stop_o)
      else $error("pulse without D3hot exit");
   chk_data_zero: assert property (
      cfg_rd_i |=> cfg_rdata_o[14:9] == 6'h00 && cfg_rdata_o[7:2] == 6'h00)
      else $error("fixed fields not zero");
   chk_bridge_byte: assert property (
      cfg_rd_i && hit_w |=> cfg_rdata_o[23:16] == 8'hc0)
      else $error("bridge byte wrong");
   chk_power_kept: assert property (!sec_power_off_o) else $error("secondary power removed");
   chk_pin_low: assert property (wake_n_o == 1'b0) else $error("wake pin level high");
endmodule // cbpm_csr_sva

bind cbpm_csr cbpm_csr_sva u_sva (.*);

// file: test/cbpm_csr_test.sv
// Self-checking bench for the power-management register bank
module cbpm_csr_test
   import cbpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 0, rst_i = 1, srst_n = 1, wr = 0, rd = 0, ev = 0, rd_pend = 0;
   logic [7:0]  addr = 0, lf = 8'h14;
   logic [3:0]  be = 0;
   logic [31:0] wd = 0, rdata, q[$];
   logic        oe, wn, pulse, keep, cstop, poff;
   int          bad_count = 0, total_checks = 0;
   always #5 mclk_i = ~mclk_i;
   cbpm_csr uut (.mclk_i(mclk_i), .rst_i(rst_i), .secondary_reset_in_n_i(srst_n), .cfg_addr_i(addr), .cfg_wr_i(wr),
      .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .wake_event_i(ev), .wake_n_o(wn),
      .wake_oe_o(oe), .d3hot_exit_reset_o(pulse), .wake_context_keep_o(keep), .sec_clk_stop_o(cstop),
      .sec_power_off_o(poff));
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Strobes last one cycle and drop before the next request
   task automatic wr_reg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge mclk_i);
      {addr, be, wd, wr} = {a, b, d, 1'b1};
      @(negedge mclk_i);
      wr = 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(negedge mclk_i);
      {addr, rd} = {a, 1'b1};
      q.push_back(e);
      @(negedge mclk_i);
      rd = 0;
   endtask
   task automatic pulse_event;
      @(negedge mclk_i);
      ev = 1;
      @(negedge mclk_i);
      ev = 0;
   endtask
   // Read data lands one cycle after the strobe edge
   always @(posedge mclk_i) rd_pend <= rd;
   always @(negedge mclk_i) if (rd_pend) cmp(rdata, q.pop_front());
   initial begin
      repeat (3000) @(posedge mclk_i);
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i) rst_i = 0;
      rd_reg(8'ha4, 32'h00c0_0000);
      for (int s = 0; s < 4; s++) begin
         lf = lfsr_next(lf);
         wr_reg(8'ha4, 4'b1101, {lf, lf, lf, lf[7:2], s[1:0]});
         cmp(cstop, s == 3);
         cmp(poff, 0);
         rd_reg(8'ha5, {16'h00c0, 14'h0, s[1:0]});
      end
      wr_reg(8'ha4, 4'b0010, 32'h0000_0100);
      wr_reg(8'ha4, 4'b0001, 32'h0);
      cmp(pulse, 1);
      cmp(cstop, 0);
      rd_reg(8'ha4, 32'h00c0_0100);
      wr_reg(8'ha4, 4'b0010, 32'h0);
      pulse_event();
      cmp(oe, 0);
      rd_reg(8'ha4, 32'h00c0_8000);
      wr_reg(8'ha4, 4'b0010, 32'h0000_0100);
      cmp(oe, 1);
      cmp(wn, 0);
      wr_reg(8'ha4, 4'b0010, 32'h0000_8100);
      cmp(oe, 0);
      rd_reg(8'ha4, 32'h00c0_0100);
      pulse_event();
      cmp(oe, 1);
      wr_reg(8'hb0, 4'hf, 32'hffff_ffff);
      wr_reg(8'ha4, 4'b0001, 32'h2);
      srst_n = 0;
      repeat (4) @(negedge mclk_i);
      srst_n = 1;
      repeat (3) @(negedge mclk_i);
      cmp(keep, 1);
      rd_reg(8'ha4, 32'h00c0_8100);
      rd_reg(8'hb0, 32'h0);
      @(negedge mclk_i) rst_i = 1;
      @(negedge mclk_i) rst_i = 0;
      rd_reg(8'ha4, 32'h00c0_0000);
      repeat (2) @(negedge mclk_i);
      wrap_up();
   end
endmodule // cbpm_csr_test
